/* File: verilog/caa_datapath.v */
// Central ALU, accumulator with post-shifter, and auxiliary register unit.
// How it works
// - ALU takes accumulator plus product or shifted input; result returns to accumulator.
// - Bus operands pass the input shifter; products pass the product shifter.
// - Saturation on: overflow sets flag and clamps to the extreme value.
// - Saturation off: overflow sets flag and raw result is kept.
// - Logical operations never overflow nor touch the overflow flag.
// - Carry follows arithmetic and one-bit shifts, not loads or logic.
// - Add-with-carry and subtract-with-borrow use the previous carry.
// - Shift-16 add only sets carry; shift-16 subtract only clears it.
// - Reset sets carry; set, clear and status load also write it.
// - Accumulator halves are stored with a 0 to 7 left shift, unchanged.
// - Upper store takes lower bits in; lower store zero-fills.
// - One-bit shifts and rotates go through carry.
// - Right shift is arithmetic when sign mode is 1; left inserts zero.
// - Variable-shift load, add, subtract use multiplier operand low four bits.
// - Variable bit test indexes by those bits; bit tests leave accumulator.
// - Normalize shifts the accumulator left.
// - Overflow, zero and carry conditions are presented for branching.
// - Computed branch target comes from the accumulator.
// - Eight auxiliary registers picked by a 3-bit pointer.
// - Auxiliary registers load from memory, accumulator, product, immediate; pointer from all but immediate.
// - Address unit modifies current register by one or register zero.
// - Input shifter shifts 0 to 16, zero low, sign top when enabled.
// - Product shifter modes: none, left one, left four, right six.
`timescale 1ns/1ps
`default_nettype none
`include "caa_defines.vh"

module caa_datapath #(
    parameter AUX_COUNT = 8
) (
    input  wire        core_clk,
    input  wire        reset_n,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output wire        overflow_condition,
    output wire        zero_condition,
    output wire        carry_flag,
    output wire [15:0] branch_target
);

    reg  [31:0] accumulator_reg;
    reg  [31:0] product_reg;
    reg  [15:0] mult_operand_reg;
    reg  [15:0] operand_reg;
    reg         carry;
    reg         overflow;
    reg         test_flag;
    reg         saturate_enable;
    reg         sign_extend_mode;
    reg  [1:0]  product_shift_mode;
    reg  [2:0]  store_shift;
    reg  [2:0]  aux_pointer;
    reg  [15:0] aux_regs [0:AUX_COUNT-1];

    wire        bus_req = wb_cyc_i & wb_stb_i;
    wire        wr_go   = bus_req & wb_we_i & wb_ack_o;
    wire        cmd_go  = wr_go & (wb_adr_i == `CAA_OFS_CMD);
    wire [4:0]  op      = wb_dat_i[`CAA_CMD_OP_MSB:`CAA_CMD_OP_LSB];
    wire [3:0]  sh_fld  = wb_dat_i[`CAA_CMD_SH_MSB:`CAA_CMD_SH_LSB];
    wire [1:0]  mod     = wb_dat_i[`CAA_CMD_MOD_MSB:`CAA_CMD_MOD_LSB];
    wire [15:0] aux_cur = aux_regs[aux_pointer];

    // Byte-lane merge for 16-bit registers; lanes 2 and 3 carry nothing.
    function [15:0] merge16;
        input [15:0] old_val;
        input [31:0] data;
        input [3:0]  sel;
        begin
            merge16 = {sel[1] ? data[15:8] : old_val[15:8], sel[0] ? data[7:0] : old_val[7:0]};
        end
    endfunction

    // Conditions for branching.
    assign overflow_condition = overflow;
    assign zero_condition     = (accumulator_reg == 32'h00000000);
    assign carry_flag         = carry;
    assign branch_target      = accumulator_reg[15:0];

    // Post-shifter: store copies never disturb the accumulator itself.
    wire [31:0] store_word = accumulator_reg << store_shift;
    wire [15:0] store_hi   = store_word[31:16];
    wire [15:0] store_lo   = store_word[15:0];

    // Input shift count: field, multiplier operand register bits, or 16.
    reg  [4:0]  in_count;
    reg  [31:0] in_ext;
    reg  [31:0] in_shifted;
    reg  [31:0] prod_shifted;
    always @* begin
        if (op == `CAA_OP_ADD_HI || op == `CAA_OP_SUB_HI) begin
            in_count = 5'h10;
        end else if (op == `CAA_OP_LOAD_VAR || op == `CAA_OP_ADD_VAR ||
                     op == `CAA_OP_SUB_VAR) begin
            in_count = {1'b0, mult_operand_reg[3:0]};
        end else begin
            in_count = {1'b0, sh_fld};
        end
        in_ext = sign_extend_mode ? {{16{operand_reg[15]}}, operand_reg}
                                  : {16'h0000, operand_reg};
        in_shifted = in_ext << in_count;
        case (product_shift_mode)
            2'b00:   prod_shifted = product_reg;
            2'b01:   prod_shifted = {product_reg[30:0], 1'b0};
            2'b10:   prod_shifted = {product_reg[27:0], 4'h0};
            default: prod_shifted = {{6{product_reg[31]}}, product_reg[31:6]};
        endcase
    end

    // Operation decode into the next_ values.
    reg  [31:0] operand_b;
    reg  [32:0] sum;
    reg  [32:0] diff;
    reg         is_add;
    reg         is_sub;
    reg         ovf_hit;
    reg  [31:0] next_acc;
    reg         next_carry;
    reg         next_overflow;
    reg         next_test;
    reg         next_sat;
    reg         next_sxm;
    reg  [2:0]  next_pointer;
    reg         aux_load;
    reg  [15:0] aux_load_val;
    reg  [3:0]  bit_index;
    always @* begin
        is_add = (op == `CAA_OP_ADD) || (op == `CAA_OP_ADD_HI) || (op == `CAA_OP_ADD_WITH_CARRY_OP) ||
                 (op == `CAA_OP_ADD_VAR) || (op == `CAA_OP_ADD_PROD);
        is_sub = (op == `CAA_OP_SUB) || (op == `CAA_OP_SUB_HI) || (op == `CAA_OP_SUB_WITH_BORROW_OP) ||
                 (op == `CAA_OP_SUB_VAR) || (op == `CAA_OP_SUB_PROD);
        operand_b = (op == `CAA_OP_LOAD_PROD || op == `CAA_OP_ADD_PROD ||
                     op == `CAA_OP_SUB_PROD) ? prod_shifted : in_shifted;
        sum  = {1'b0, accumulator_reg} + {1'b0, operand_b} +
               {32'h00000000, (op == `CAA_OP_ADD_WITH_CARRY_OP) & carry};
        diff = {1'b0, accumulator_reg} - {1'b0, operand_b} -
               {32'h00000000, (op == `CAA_OP_SUB_WITH_BORROW_OP) & ~carry};
        next_acc      = accumulator_reg;
        next_carry    = carry;
        next_overflow = overflow;
        next_test     = test_flag;
        next_sat      = saturate_enable;
        next_sxm      = sign_extend_mode;
        next_pointer  = aux_pointer;
        aux_load      = 1'b0;
        aux_load_val  = aux_cur;
        bit_index     = (op == `CAA_OP_BIT_VAR) ? mult_operand_reg[3:0] : sh_fld;
        ovf_hit       = 1'b0;
        if (is_add) begin
            next_acc = sum[31:0];
            ovf_hit  = (accumulator_reg[31] == operand_b[31]) &&
                       (sum[31] != accumulator_reg[31]);
            if (op == `CAA_OP_ADD_HI) begin
                next_carry = carry | sum[32];
            end else begin
                next_carry = sum[32];
            end
        end else if (is_sub) begin
            next_acc = diff[31:0];
            ovf_hit  = (accumulator_reg[31] != operand_b[31]) &&
                       (diff[31] != accumulator_reg[31]);
            if (op == `CAA_OP_SUB_HI) begin
                next_carry = carry & ~diff[32];
            end else begin
                next_carry = ~diff[32];
            end
        end else begin
            case (op)
                `CAA_OP_LOAD, `CAA_OP_LOAD_VAR, `CAA_OP_LOAD_PROD: begin
                    next_acc = operand_b;
                end
                // Logic ops leave carry and overflow alone.
                `CAA_OP_AND: begin
                    next_acc = accumulator_reg & in_shifted;
                end
                `CAA_OP_OR: begin
                    next_acc = accumulator_reg | in_shifted;
                end
                `CAA_OP_XOR: begin
                    next_acc = accumulator_reg ^ in_shifted;
                end
                `CAA_OP_SFL: begin
                    next_acc   = {accumulator_reg[30:0], 1'b0};
                    next_carry = accumulator_reg[31];
                end
                `CAA_OP_SFR: begin
                    next_acc   = {sign_extend_mode & accumulator_reg[31],
                                  accumulator_reg[31:1]};
                    next_carry = accumulator_reg[0];
                end
                `CAA_OP_ROL: begin
                    next_acc   = {accumulator_reg[30:0], carry};
                    next_carry = accumulator_reg[31];
                end
                `CAA_OP_ROR: begin
                    next_acc   = {carry, accumulator_reg[31:1]};
                    next_carry = accumulator_reg[0];
                end
                // One normalize step; software repeats it until the sign bits differ.
                `CAA_OP_NORMALIZE_OP: begin
                    if (accumulator_reg != 32'h00000000 &&
                        accumulator_reg[31] == accumulator_reg[30]) begin
                        next_acc = {accumulator_reg[30:0], 1'b0};
                    end
                end
                `CAA_OP_BIT, `CAA_OP_BIT_VAR: begin
                    next_test = operand_reg[bit_index];
                end
                // Field 0 picks carry, 1 saturation, 2 sign extension.
                `CAA_OP_SET_FLAG_OP, `CAA_OP_CLEAR_FLAG_OP: begin
                    if (sh_fld == 4'h0) begin
                        next_carry = (op == `CAA_OP_SET_FLAG_OP);
                    end else if (sh_fld == 4'h1) begin
                        next_sat = (op == `CAA_OP_SET_FLAG_OP);
                    end else if (sh_fld == 4'h2) begin
                        next_sxm = (op == `CAA_OP_SET_FLAG_OP);
                    end
                end
                `CAA_OP_AUX_ACC: begin
                    aux_load     = 1'b1;
                    aux_load_val = accumulator_reg[15:0];
                end
                `CAA_OP_AUX_PROD: begin
                    aux_load     = 1'b1;
                    aux_load_val = product_reg[15:0];
                end
                `CAA_OP_AUX_OPND: begin
                    aux_load     = 1'b1;
                    aux_load_val = operand_reg;
                end
                `CAA_OP_PTR_ACC: begin
                    next_pointer = accumulator_reg[2:0];
                end
                `CAA_OP_PTR_PROD: begin
                    next_pointer = product_reg[2:0];
                end
                default: begin
                    next_acc = accumulator_reg;
                end
            endcase
        end
        // Saturation clamps by the pre-operation accumulator sign.
        if (ovf_hit) begin
            next_overflow = 1'b1;
            if (saturate_enable) begin
                next_acc = accumulator_reg[31] ? `CAA_SAT_NEG : `CAA_SAT_POS;
            end
        end
    end

    // Address unit: a load of the current register beats its modify.
    reg  [15:0] next_aux_cur;
    always @* begin
        case (mod)
            `CAA_MOD_INC:     next_aux_cur = aux_cur + 16'h0001;
            `CAA_MOD_DEC:     next_aux_cur = aux_cur - 16'h0001;
            `CAA_MOD_ADD_AR0: next_aux_cur = aux_cur + aux_regs[0];
            default:          next_aux_cur = aux_cur;
        endcase
        if (aux_load) begin
            next_aux_cur = aux_load_val;
        end
    end

    wire aux_cmd_wr = cmd_go & (aux_load | (mod != `CAA_MOD_NONE));
    wire aux_bus_wr = wr_go & (wb_adr_i == `CAA_OFS_AUX_CUR);

    // One flop group per auxiliary register; only the pointed one changes.
    genvar gi;
    generate
        for (gi = 0; gi < AUX_COUNT; gi = gi + 1) begin : g_aux
            always @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    aux_regs[gi] <= 16'h0000;
                end else if (aux_pointer == gi) begin
                    if (aux_bus_wr) begin
                        aux_regs[gi] <= merge16(aux_cur, wb_dat_i, wb_sel_i);
                    end else if (aux_cmd_wr) begin
                        aux_regs[gi] <= next_aux_cur;
                    end
                end
            end
        end
    endgenerate

    // Datapath and bus-written registers.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            accumulator_reg    <= 32'h00000000;
            product_reg        <= 32'h00000000;
            mult_operand_reg   <= 16'h0000;
            operand_reg        <= 16'h0000;
            carry              <= `CAA_RST_CARRY;
            overflow           <= 1'b0;
            test_flag          <= 1'b0;
            {store_shift, product_shift_mode, sign_extend_mode, saturate_enable} <= `CAA_RST_CTRL;
            aux_pointer        <= 3'h0;
        end else if (cmd_go) begin
            accumulator_reg    <= next_acc;
            carry              <= next_carry;
            overflow           <= next_overflow;
            test_flag          <= next_test;
            saturate_enable    <= next_sat;
            sign_extend_mode   <= next_sxm;
            aux_pointer        <= next_pointer;
        end else if (wr_go) begin
            if (wb_adr_i == `CAA_OFS_OPERAND) begin
                operand_reg <= merge16(operand_reg, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == `CAA_OFS_MULT_OPND) begin
                mult_operand_reg <= merge16(mult_operand_reg, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == `CAA_OFS_PROD_LO) begin
                product_reg[15:0] <= merge16(product_reg[15:0], wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == `CAA_OFS_PROD_HI) begin
                product_reg[31:16] <= merge16(product_reg[31:16], wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == `CAA_OFS_AUX_PTR && wb_sel_i[0]) begin
                aux_pointer <= wb_dat_i[2:0];
            end else if (wb_adr_i == `CAA_OFS_CTRL && wb_sel_i[0]) begin
                saturate_enable    <= wb_dat_i[`CAA_CTRL_SAT];
                sign_extend_mode   <= wb_dat_i[`CAA_CTRL_SXM];
                product_shift_mode <= wb_dat_i[`CAA_CTRL_PM_MSB:`CAA_CTRL_PM_LSB];
                store_shift        <= wb_dat_i[`CAA_CTRL_ST_MSB:`CAA_CTRL_ST_LSB];
            end else if (wb_adr_i == `CAA_OFS_STATUS && wb_sel_i[0]) begin
                carry     <= wb_dat_i[`CAA_ST_CARRY];
                overflow  <= wb_dat_i[`CAA_ST_OVF];
                test_flag <= wb_dat_i[`CAA_ST_TEST];
            end
        end
    end

    // Read mux; unmapped offsets read as zero.
    reg  [31:0] rd_word;
    always @* begin
        if (wb_adr_i == `CAA_OFS_CTRL) begin
            rd_word = {25'h0000000, store_shift, product_shift_mode,
                       sign_extend_mode, saturate_enable};
        end else if (wb_adr_i == `CAA_OFS_STATUS) begin
            rd_word = {28'h0000000, test_flag, zero_condition, overflow, carry};
        end else if (wb_adr_i == `CAA_OFS_OPERAND) begin
            rd_word = {16'h0000, operand_reg};
        end else if (wb_adr_i == `CAA_OFS_ACC_LO) begin
            rd_word = {16'h0000, accumulator_reg[15:0]};
        end else if (wb_adr_i == `CAA_OFS_ACC_HI) begin
            rd_word = {16'h0000, accumulator_reg[31:16]};
        end else if (wb_adr_i == `CAA_OFS_STORE_HI) begin
            rd_word = {16'h0000, store_hi};
        end else if (wb_adr_i == `CAA_OFS_STORE_LO) begin
            rd_word = {16'h0000, store_lo};
        end else if (wb_adr_i == `CAA_OFS_MULT_OPND) begin
            rd_word = {16'h0000, mult_operand_reg};
        end else if (wb_adr_i == `CAA_OFS_PROD_LO) begin
            rd_word = {16'h0000, product_reg[15:0]};
        end else if (wb_adr_i == `CAA_OFS_PROD_HI) begin
            rd_word = {16'h0000, product_reg[31:16]};
        end else if (wb_adr_i == `CAA_OFS_AUX_PTR) begin
            rd_word = {29'h00000000, aux_pointer};
        end else if (wb_adr_i == `CAA_OFS_AUX_CUR) begin
            rd_word = {16'h0000, aux_cur};
        end else if (wb_adr_i == `CAA_OFS_BRANCH) begin
            rd_word = {16'h0000, branch_target};
        end else begin
            rd_word = 32'h00000000;
        end
    end

    // Bus slave: ack one cycle after the request, dropped the cycle after.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            if (bus_req & ~wb_ack_o & ~wb_we_i) begin
                wb_dat_o <= rd_word;
            end
        end
    end

endmodule
`default_nettype wire

/* File: verilog/caa_defines.vh */
// Constants for the central ALU, accumulator and auxiliary address datapath.
`ifndef CAA_DEFINES_VH
`define CAA_DEFINES_VH

// Register byte offsets.
`define CAA_OFS_CMD       8'h00
`define CAA_OFS_OPERAND   8'h04
`define CAA_OFS_CTRL      8'h08
`define CAA_OFS_STATUS    8'h0C
`define CAA_OFS_ACC_LO    8'h10
`define CAA_OFS_ACC_HI    8'h14
`define CAA_OFS_STORE_HI  8'h18
`define CAA_OFS_STORE_LO  8'h1C
`define CAA_OFS_MULT_OPND 8'h20
`define CAA_OFS_PROD_LO   8'h24
`define CAA_OFS_PROD_HI   8'h28
`define CAA_OFS_AUX_PTR   8'h2C
`define CAA_OFS_AUX_CUR   8'h30
`define CAA_OFS_BRANCH    8'h34

// Command word fields.
`define CAA_CMD_OP_MSB    4
`define CAA_CMD_OP_LSB    0
`define CAA_CMD_SH_MSB    8
`define CAA_CMD_SH_LSB    5
`define CAA_CMD_MOD_MSB   11
`define CAA_CMD_MOD_LSB   10

// Control word fields.
`define CAA_CTRL_SAT      0
`define CAA_CTRL_SXM      1
`define CAA_CTRL_PM_MSB   3
`define CAA_CTRL_PM_LSB   2
`define CAA_CTRL_ST_MSB   6
`define CAA_CTRL_ST_LSB   4

// Status word fields.
`define CAA_ST_CARRY      0
`define CAA_ST_OVF        1
`define CAA_ST_ZERO       2
`define CAA_ST_TEST       3

// Reset values.
`define CAA_RST_CARRY     1'b1
`define CAA_RST_CTRL      7'h00

// Saturation limits.
`define CAA_SAT_POS       32'h7FFFFFFF
`define CAA_SAT_NEG       32'h80000000

// Operation codes.
`define CAA_OP_NOP        5'h00
`define CAA_OP_LOAD       5'h01
`define CAA_OP_ADD        5'h02
`define CAA_OP_SUB        5'h03
`define CAA_OP_ADD_HI     5'h04
`define CAA_OP_SUB_HI     5'h05
`define CAA_OP_ADD_WITH_CARRY_OP       5'h06
`define CAA_OP_SUB_WITH_BORROW_OP       5'h07
`define CAA_OP_AND        5'h08
`define CAA_OP_OR         5'h09
`define CAA_OP_XOR        5'h0A
`define CAA_OP_LOAD_VAR   5'h0B
`define CAA_OP_ADD_VAR    5'h0C
`define CAA_OP_SUB_VAR    5'h0D
`define CAA_OP_LOAD_PROD  5'h0E
`define CAA_OP_ADD_PROD   5'h0F
`define CAA_OP_SUB_PROD   5'h10
`define CAA_OP_SFL        5'h11
`define CAA_OP_SFR        5'h12
`define CAA_OP_ROL        5'h13
`define CAA_OP_ROR        5'h14
`define CAA_OP_NORMALIZE_OP       5'h15
`define CAA_OP_BIT        5'h16
`define CAA_OP_BIT_VAR    5'h17
`define CAA_OP_SET_FLAG_OP       5'h18
`define CAA_OP_CLEAR_FLAG_OP       5'h19
`define CAA_OP_AUX_ACC    5'h1A
`define CAA_OP_AUX_PROD   5'h1B
`define CAA_OP_AUX_OPND   5'h1C
`define CAA_OP_PTR_ACC    5'h1D
`define CAA_OP_PTR_PROD   5'h1E

// Auxiliary modify modes.
`define CAA_MOD_NONE      2'b00
`define CAA_MOD_INC       2'b01
`define CAA_MOD_DEC       2'b10
`define CAA_MOD_ADD_AR0   2'b11

`endif

/* File: sim/caa_checker.sv */
// Assertion checker for the ALU, accumulator and auxiliary datapath.
`timescale 1ns/1ps
`default_nettype none
module caa_checker (
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        overflow_condition,
    input wire logic        zero_condition,
    input wire logic        carry_flag,
    input wire logic [15:0] branch_target
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // Command word at its executing edge; 1FF means none.
    wire logic       wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    wire logic [8:0] cw = (wr && wb_adr_i == 8'h00) ? wb_dat_i[8:0] : 9'h1FF;
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_zero_flag: assert property (zero_condition |-> branch_target == 16'h0000)
        else $error("zero flag with nonzero accumulator");
    a_carry_set: assert property (cw == 9'h018 |=> carry_flag)
        else $error("carry not set");
    a_carry_clear: assert property (cw == 9'h019 |=> !carry_flag)
        else $error("carry not cleared");
    a_logic_no_ovf: assert property (cw[4:0] inside {5'h08, 5'h09, 5'h0A} |=>
        $stable(overflow_condition)) else $error("logic op moved overflow");
    a_load_carry: assert property (cw[4:0] inside {5'h01, 5'h08, 5'h0A, 5'h0E} |=>
        $stable(carry_flag)) else $error("load or logic op moved carry");
    a_bit_keeps: assert property (cw[4:1] == 4'hB |=>
        $stable(branch_target) && $stable(zero_condition)) else $error("bit test moved acc");
    a_carry_quiet: assert property (!(wr && wb_adr_i inside {8'h00, 8'h0C}) |=>
        $stable(carry_flag)) else $error("carry moved without command");
    a_read_keeps: assert property (wb_cyc_i && wb_stb_i && !wb_we_i |=>
        $stable(branch_target)) else $error("read changed accumulator");
    // Main scenarios.
    c_set: cover property (cw == 9'h018);
    c_ovf: cover property ($rose(overflow_condition));
    c_rotate: cover property (cw[4:0] == 5'h13);
endmodule
bind caa_datapath caa_checker chk (.core_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_i, .wb_ack_o, .overflow_condition, .zero_condition, .carry_flag,
    .branch_target);
`default_nettype wire

/* File: sim/caa_bus_master.sv */
// Wishbone master for the core's instruction control.
`timescale 1ns/1ps
`default_nettype none
module caa_bus_master (
    input  wire logic        core_clk,
    input  wire logic        wb_ack_o,
    input  wire logic [31:0] wb_dat_o,
    output var  logic        wb_cyc_i,
    output var  logic        wb_stb_i,
    output var  logic        wb_we_i,
    output var  logic [7:0]  wb_adr_i,
    output var  logic [3:0]  wb_sel_i,
    output var  logic [31:0] wb_dat_i
);
    int slow = 0;
    // Idle bus at time zero.
    initial {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} =
        {3'h0, 8'h00, 4'hF, 32'h00000000};
    // One classic cycle; released lines show inverted data.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        repeat (slow) @(posedge core_clk);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge core_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        wb_adr_i <= ~a;
        wb_dat_i <= ~d;
    endtask
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the ALU, accumulator and auxiliary datapath.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        core_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic        overflow_condition, zero_condition, carry_flag;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [15:0] branch_target;
    int          bad_count = 0;
    int          n_tests = 0;
    logic [4:0]  sh_op [5] = '{5'h13, 5'h14, 5'h12, 5'h11, 5'h12};
    logic [31:0] sh_acc [5] = '{32'h2, 32'h80000001, 32'h40000000, 32'h80000000, 32'hC0000000};
    logic [4:0]  sh_c = 5'b00101;
    logic [31:0] pm_acc [4] = '{32'h100, 32'h200, 32'h1000, 32'h4};
    // Free-running 50 MHz core clock.
    always #10 core_clk = ~core_clk;
    caa_datapath dut (.core_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .overflow_condition, .zero_condition,
        .carry_flag, .branch_target);
    caa_bus_master m (.core_clk, .wb_ack_o, .wb_dat_o, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i);
    task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        m.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        m.xfer(1'b0, a, 32'h0, q);
        ck(n, e, q);
    endtask
    task automatic op(input logic [4:0] o, input logic [3:0] f, input logic [1:0] md = 2'b00);
        w(8'h00, {20'h0, md, 1'b0, f, o});
    endtask
    task automatic acc(input logic [31:0] e);
        rd(8'h10, {16'h0, e[15:0]}, "acc lo");
        rd(8'h14, {16'h0, e[31:16]}, "acc hi");
    endtask
    // Flags are sampled mid-cycle, clear of the updating edge.
    task automatic fl(input logic c, input logic v);
        @(negedge core_clk);
        ck("carry", {31'h0, c}, {31'h0, carry_flag});
        ck("overflow", {31'h0, v}, {31'h0, overflow_condition});
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Watchdog, well beyond the run length.
    initial begin
        #100000;
        bad_count++;
        end_of_test();
    end
    // Test sequence.
    initial begin
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        fl(1'b1, 1'b0);
        ck("zero", 32'h1, {31'h0, zero_condition});
        w(8'h04, 32'h8001);
        op(5'h01, 4'h4);
        acc(32'h00080010);
        w(8'h08, 32'h2);
        op(5'h01, 4'h0);
        acc(32'hFFFF8001);
        w(8'h08, 32'h40);
        w(8'h04, 32'h5678);
        op(5'h01, 4'h0);
        w(8'h04, 32'h1234);
        op(5'h04, 4'h0);
        rd(8'h18, 32'h2345, "store hi");
        rd(8'h1C, 32'h6780, "store lo");
        acc(32'h12345678);
        rd(8'h34, 32'h5678, "branch");
        rd(8'h3C, 32'h0, "unmapped");
        $display("test shifters done");
        w(8'h08, 32'h1);
        w(8'h04, 32'h7000);
        op(5'h04, 4'h0);
        acc(32'h7FFFFFFF);
        fl(1'b1, 1'b1);
        w(8'h0C, 32'h0);
        fl(1'b0, 1'b0);
        w(8'h08, 32'h0);
        op(5'h04, 4'h0);
        acc(32'hEFFFFFFF);
        op(5'h0A, 4'h0);
        acc(32'hEFFF8FFF);
        fl(1'b0, 1'b1);
        w(8'h0C, 32'h0);
        op(5'h18, 4'h0);
        w(8'h04, 32'h1000);
        op(5'h05, 4'h0);
        fl(1'b1, 1'b0);
        op(5'h19, 4'h0);
        op(5'h04, 4'h0);
        acc(32'hEFFF8FFF);
        fl(1'b0, 1'b0);
        op(5'h18, 4'h0);
        w(8'h04, 32'h3);
        op(5'h01, 4'h0);
        op(5'h06, 4'h0);
        op(5'h06, 4'h0);
        acc(32'hA);
        op(5'h07, 4'h0);
        acc(32'h6);
        fl(1'b1, 1'b0);
        $display("test carry and overflow done");
        w(8'h04, 32'h1);
        op(5'h01, 4'h0);
        w(8'h04, 32'h8000);
        op(5'h04, 4'h0);
        op(5'h19, 4'h0);
        foreach (sh_op[i]) begin
            if (i == 4)
                w(8'h08, 32'h2);
            op(sh_op[i], 4'h0);
            acc(sh_acc[i]);
            fl(sh_c[i], 1'b0);
        end
        op(5'h15, 4'h0);
        acc(32'h80000000);
        $display("test shift and rotate done");
        w(8'h20, 32'h4);
        w(8'h04, 32'h10);
        op(5'h0B, 4'h0);
        op(5'h0C, 4'h0);
        acc(32'h200);
        op(5'h0D, 4'h0);
        op(5'h17, 4'h0);
        rd(8'h0C, 32'h9, "status");
        op(5'h16, 4'h0);
        rd(8'h0C, 32'h1, "status");
        acc(32'h100);
        w(8'h24, 32'h100);
        w(8'h28, 32'h0);
        for (int k = 0; k < 4; k++) begin
            w(8'h08, {28'h0, k[1:0], 2'b00});
            op(5'h0E, 4'h0);
            acc(pm_acc[k]);
        end
        $display("test variable shift and product done");
        m.slow = 2;
        w(8'h2C, 32'h0);
        w(8'h30, 32'h10);
        w(8'h2C, 32'h3);
        w(8'h30, 32'h100);
        op(5'h00, 4'h0, 2'b01);
        rd(8'h30, 32'h101, "aux");
        op(5'h00, 4'h0, 2'b11);
        op(5'h00, 4'h0, 2'b10);
        rd(8'h30, 32'h110, "aux");
        w(8'h2C, 32'h0);
        rd(8'h30, 32'h10, "aux zero");
        op(5'h1D, 4'h0);
        rd(8'h2C, 32'h4, "pointer");
        $display("test auxiliary done");
        end_of_test();
    end
endmodule
`default_nettype wire
